/* File: bench/scl_far_model.sv */
`timescale 1ns/1ps
module scl_far_model (
	input wire logic mclk,
	input wire logic scl,
	output int low_len,
	output int high_len
);
	int run = 0;
	logic prev = 1'b1;
	// far side only measures; it never stretches the master clock
	always @(posedge mclk) begin
		prev <= scl;
		if (scl != prev) begin
			if (prev) high_len <= run;
			else low_len <= run;
			run <= 1;
		end else begin
			run <= run + 1;
		end
	end
endmodule // scl_far_model

/* File: bench/serializer_i2c_timing_datapath_regs_tb_top.sv */
`timescale 1ns/1ps
module serializer_i2c_timing_datapath_regs_tb_top;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0, reg_rd = 1'b0, ste = 1'b0, clr = 1'b0, err = 1'b0;
	logic run = 1'b0, stretch = 1'b0;
	logic strap = 1'b1, rep = 1'b0, ibv = 1'b0, ibs = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, hi_cnt, lo_cnt;
	logic scl, rel, wide, surr, dit, aux;
	int lo_len, hi_len;
	int n_mismatch = 0;
	int samples_checked = 0;
	always #2 mclk = ~mclk;
	serializer_i2c_timing_datapath_regs DUT (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.mode_strap_pin0(strap), .self_test_enable(ste), .crc_count_clear(clr),
		.backchannel_crc_errors(err), .repeater_mode(rep), .inband_surround_valid(ibv),
		.inband_surround(ibs), .master_scl_run(run), .master_scl_out(scl),
		.slave_stretch_req(stretch), .slave_scl_release(rel), .wide_payload_mode(wide),
		.surround_audio(surr), .data_island_transport(dit), .aux_audio_enable(aux),
		.scl_high_count(hi_cnt), .scl_low_count(lo_cnt));
	scl_far_model far (.mclk(mclk), .scl(scl), .low_len(lo_len), .high_len(hi_len));
	task automatic final_report;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
		@(posedge mclk);
	endtask
	task automatic t_defaults;
		rdc(8'h18, i2c_timing_pkg::scl_period_reset);
		rdc(8'h19, i2c_timing_pkg::scl_period_reset);
		rdc(8'h1a, 8'h08);
		rdc(8'h1b, 8'h00);
		check({7'h00, aux}, 8'h01);
		check(hi_cnt, i2c_timing_pkg::scl_period_reset);
		check(lo_cnt, i2c_timing_pkg::scl_period_reset);
	endtask
	task automatic t_regs;
		wr(8'h18, 8'h02);
		wr(8'h19, 8'h03);
		wr(8'h1b, 8'h55);
		wr(8'h1a, 8'hff);
		rdc(8'h18, 8'h02);
		rdc(8'h19, 8'h03);
		rdc(8'h1b, 8'h00);
		rdc(8'h1a, 8'h0b);
		rdc(8'h20, 8'h00);
		check({5'h00, wide, surr, dit}, 8'h07);
		check(hi_cnt, 8'h02);
		check(lo_cnt, 8'h03);
		wr(8'h1a, 8'h02);
		cyc(2);
		check({6'h00, wide, surr}, 8'h02);
		rep <= 1'b1;
		ibv <= 1'b1;
		ibs <= 1'b1;
		cyc(2);
		check({6'h00, surr, dit}, 8'h03);
		rdc(8'h1a, 8'h0a);
		rep <= 1'b0;
		ibv <= 1'b0;
		ibs <= 1'b0;
		cyc(2);
		check({6'h00, wide, surr}, 8'h02);
	endtask
	task automatic t_master;
		run <= 1'b1;
		cyc(60);
		// a restart cycle may add one to each phase
		check(8'(lo_len inside {8, 9}), 8'h01);
		check(8'(hi_len inside {7, 8}), 8'h01);
		run <= 1'b0;
		cyc(20);
	endtask
	task automatic t_slave;
		int n;
		n = 0;
		stretch <= 1'b1;
		@(posedge mclk);
		while (rel !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 50) begin
			n_mismatch++;
			final_report();
		end
		// low count 3 plus 5, then the timer flag and the release register
		check(8'(n), 8'h0a);
		stretch <= 1'b0;
		cyc(4);
	endtask
	task automatic t_crc;
		err <= 1'b1;
		cyc(8);
		err <= 1'b0;
		cyc(4);
		rdc(8'h1b, 8'h00);
		ste <= 1'b1;
		cyc(4);
		err <= 1'b1;
		cyc(10);
		err <= 1'b0;
		cyc(4);
		rdc(8'h1b, 8'h0a);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		rdc(8'h1b, 8'h00);
		err <= 1'b1;
		cyc(300);
		err <= 1'b0;
		cyc(4);
		rdc(8'h1b, i2c_timing_pkg::crc_count_max);
		ste <= 1'b0;
		cyc(4);
		ste <= 1'b1;
		cyc(6);
		rdc(8'h1b, 8'h00);
	endtask
	initial begin
		cyc(2);
		reset <= 1'b0;
		cyc(8);
		t_defaults();
		t_regs();
		t_master();
		t_slave();
		t_crc();
		final_report();
	end
endmodule // serializer_i2c_timing_datapath_regs_tb_top

/* File: core/i2c_timing_pkg.sv */
package i2c_timing_pkg;
	localparam logic [7:0] addr_scl_high = 8'h18;
	localparam logic [7:0] addr_scl_low = 8'h19;
	localparam logic [7:0] addr_datapath = 8'h1a;
	localparam logic [7:0] addr_crc_count = 8'h1b;
	localparam logic [7:0] scl_period_reset = 8'h7f;
	localparam logic [7:0] crc_count_max = 8'hff;
	localparam logic [7:0] zero_byte = 8'h00;
	localparam int surround_bit = 0;
	localparam int wide_bit = 1;
	localparam int aux_audio_bit = 3;
	localparam logic [8:0] extra_periods = 9'h005;
	localparam logic [1:0] datapath_reset = 2'h0;
endpackage

/* File: core/scl_period_timer.sv */
`timescale 1ns/1ps
module scl_period_timer (
	input wire logic mclk,
	input wire logic reset,
	input wire logic start,
	input wire logic [7:0] count,
	output logic done
);
	logic [8:0] left_r;
	logic busy_r;
	logic [8:0] left_nxt;
	assign left_nxt = start ? ({1'b0, count} + i2c_timing_pkg::extra_periods - 9'h001)
		: ((busy_r & (left_r != 9'h000)) ? left_r - 9'h001 : left_r);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			left_r <= 9'h000;
			busy_r <= 1'b0;
			done <= 1'b0;
		end else begin
			left_r <= left_nxt;
			busy_r <= start | (busy_r & (left_r != 9'h000));
			done <= busy_r & ~start & (left_r == 9'h000);
		end
	end
endmodule // scl_period_timer

/* File: core/serializer_i2c_timing_datapath_regs.sv */
`timescale 1ns/1ps
module serializer_i2c_timing_datapath_regs (
	input wire logic mclk,
	input wire logic reset,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic mode_strap_pin0,
	input wire logic self_test_enable,
	input wire logic crc_count_clear,
	input wire logic backchannel_crc_errors,
	input wire logic repeater_mode,
	input wire logic inband_surround_valid,
	input wire logic inband_surround,
	input wire logic master_scl_run,
	output logic master_scl_out,
	input wire logic slave_stretch_req,
	output logic slave_scl_release,
	output logic wide_payload_mode,
	output logic surround_audio,
	output logic data_island_transport,
	output logic aux_audio_enable,
	output logic [7:0] scl_high_count,
	output logic [7:0] scl_low_count
);
	logic [7:0] scl_high_period_r;
	logic [7:0] scl_low_period_r;
	logic [1:0] datapath_r;
	logic [7:0] crc_count_r;
	logic strap_s1_r, strap_s2_r, strap_done_r, aux_audio_r;
	logic strap_ready_r, aux_latched_r, master_active_r;
	logic test_s1_r, test_s2_r, test_prev_r;
	logic err_s1_r, err_s2_r;
	logic slave_active_r, slave_stretch_prev_r;
	logic [7:0] rdata_nxt;
	logic [7:0] crc_count_nxt;
	logic test_start, wr_high, wr_low, wr_dp, surround_nxt;
	logic timer_start, timer_done, slave_start;
	logic [7:0] timer_count;

	assign wr_high = reg_wr & (reg_addr == i2c_timing_pkg::addr_scl_high);
	assign wr_low = reg_wr & (reg_addr == i2c_timing_pkg::addr_scl_low);
	// counter address has no write path at all
	assign wr_dp = reg_wr & (reg_addr == i2c_timing_pkg::addr_datapath);
	assign test_start = test_s2_r & ~test_prev_r;
	// a new error in the clear cycle is dropped; clearing restarts the run
	assign crc_count_nxt = (test_start | crc_count_clear) ? i2c_timing_pkg::zero_byte
		: (test_s2_r & err_s2_r & (crc_count_r != i2c_timing_pkg::crc_count_max))
		? crc_count_r + 8'h01 : crc_count_r;
	// repeater follows in-band detection while it is valid
	assign surround_nxt = (repeater_mode & inband_surround_valid) ? inband_surround
		: datapath_r[i2c_timing_pkg::surround_bit];
	assign rdata_nxt = (reg_addr == i2c_timing_pkg::addr_scl_high) ? scl_high_period_r
		: (reg_addr == i2c_timing_pkg::addr_scl_low) ? scl_low_period_r
		: (reg_addr == i2c_timing_pkg::addr_datapath)
		? {4'h0, aux_audio_r, 1'b0, datapath_r}
		: (reg_addr == i2c_timing_pkg::addr_crc_count) ? crc_count_r
		: i2c_timing_pkg::zero_byte;

	// one timer is shared: a slave setup start takes it over from a running master phase
	assign slave_start = slave_stretch_req & ~slave_stretch_prev_r;
	// release pulse restarts a master whose phase the slave wait cut short
	assign timer_start = slave_start | (master_scl_run & ~slave_active_r
		& (timer_done | ~master_active_r | slave_scl_release));
	// count of the phase about to start: low first, then alternate
	assign timer_count = (slave_start | ~master_active_r | master_scl_out)
		? scl_low_period_r : scl_high_period_r;

	scl_period_timer u_timer (
		.mclk(mclk),
		.reset(reset),
		.start(timer_start),
		.count(timer_count),
		.done(timer_done)
	);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			scl_high_period_r <= i2c_timing_pkg::scl_period_reset;
			scl_low_period_r <= i2c_timing_pkg::scl_period_reset;
		end else begin
			if (wr_high) scl_high_period_r <= reg_wdata;
			if (wr_low) scl_low_period_r <= reg_wdata;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			datapath_r <= i2c_timing_pkg::datapath_reset;
		end else if (wr_dp) begin
			datapath_r <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			strap_s1_r <= 1'b0;
			strap_s2_r <= 1'b0;
			strap_done_r <= 1'b0;
			strap_ready_r <= 1'b0;
			aux_audio_r <= 1'b0;
		end else begin
			strap_s1_r <= mode_strap_pin0;
			strap_s2_r <= strap_s1_r;
			strap_done_r <= 1'b1;
			strap_ready_r <= strap_done_r;
			// second stage holds the pin only from the second edge on
			if (strap_ready_r & ~aux_latched_r) aux_audio_r <= strap_s2_r;
		end
	end
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) aux_latched_r <= 1'b0;
		else if (strap_ready_r) aux_latched_r <= 1'b1;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			test_s1_r <= 1'b0;
			test_s2_r <= 1'b0;
			test_prev_r <= 1'b0;
			err_s1_r <= 1'b0;
			err_s2_r <= 1'b0;
			crc_count_r <= i2c_timing_pkg::zero_byte;
		end else begin
			test_s1_r <= self_test_enable;
			test_s2_r <= test_s1_r;
			test_prev_r <= test_s2_r;
			err_s1_r <= backchannel_crc_errors;
			err_s2_r <= err_s1_r;
			crc_count_r <= crc_count_nxt;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			master_active_r <= 1'b0;
			master_scl_out <= 1'b1;
			slave_active_r <= 1'b0;
			slave_stretch_prev_r <= 1'b0;
			slave_scl_release <= 1'b0;
		end else begin
			slave_stretch_prev_r <= slave_stretch_req;
			slave_scl_release <= slave_active_r & timer_done;
			if (slave_start) slave_active_r <= 1'b1;
			else if (timer_done) slave_active_r <= 1'b0;
			if (!master_scl_run) begin
				master_active_r <= 1'b0;
				master_scl_out <= 1'b1;
			end else if (timer_start & ~slave_start) begin
				master_active_r <= 1'b1;
				master_scl_out <= master_active_r ? ~master_scl_out : 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			reg_rdata <= i2c_timing_pkg::zero_byte;
			wide_payload_mode <= 1'b0;
			surround_audio <= 1'b0;
			data_island_transport <= 1'b0;
			aux_audio_enable <= 1'b0;
			scl_high_count <= i2c_timing_pkg::scl_period_reset;
			scl_low_count <= i2c_timing_pkg::scl_period_reset;
		end else begin
			if (reg_rd) reg_rdata <= rdata_nxt;
			wide_payload_mode <= datapath_r[i2c_timing_pkg::wide_bit];
			surround_audio <= surround_nxt;
			data_island_transport <= surround_nxt;
			aux_audio_enable <= aux_audio_r;
			scl_high_count <= scl_high_period_r;
			scl_low_count <= scl_low_period_r;
		end
	end

	a_crc_saturate: assert property (@(posedge mclk) disable iff (reset)
		crc_count_r == i2c_timing_pkg::crc_count_max && !test_start && !crc_count_clear
		|=> crc_count_r == i2c_timing_pkg::crc_count_max)
		else $error("crc count left saturation");
	a_crc_clear: assert property (@(posedge mclk) disable iff (reset)
		crc_count_clear |=> crc_count_r == i2c_timing_pkg::zero_byte)
		else $error("crc count not cleared");
	a_scl_reset_val: assert property (@(posedge mclk)
		$fell(reset) |-> scl_high_period_r == i2c_timing_pkg::scl_period_reset)
		else $error("scl high reset wrong");
	a_high_write: assert property (@(posedge mclk) disable iff (reset)
		wr_high |=> scl_high_period_r == $past(reg_wdata))
		else $error("high period not written");
	a_ro_count_write: assert property (@(posedge mclk) disable iff (reset)
		reg_wr && reg_addr == i2c_timing_pkg::addr_crc_count && !test_start
		&& !crc_count_clear && !(test_s2_r && err_s2_r) |=> $stable(crc_count_r))
		else $error("counter took a write");
	a_surround_out: assert property (@(posedge mclk) disable iff (reset)
		surround_audio == data_island_transport)
		else $error("surround without data island");
	a_wide_follow: assert property (@(posedge mclk) disable iff (reset)
		wr_dp ##2 !$past(wr_dp) |-> wide_payload_mode == $past(reg_wdata[1], 2))
		else $error("wide mode mismatch");
	a_slave_release: assert property (@(posedge mclk) disable iff (reset)
		slave_start |-> !slave_scl_release [*6])
		else $error("scl released early");
	a_low_first: assert property (@(posedge mclk) disable iff (reset)
		timer_start && !slave_start && !master_active_r |-> timer_count == scl_low_period_r)
		else $error("master did not start low");
	a_high_phase: assert property (@(posedge mclk) disable iff (reset)
		timer_start && !slave_start && master_active_r && !master_scl_out
		|-> timer_count == scl_high_period_r)
		else $error("high phase used wrong count");
	a_master_idle: assert property (@(posedge mclk) disable iff (reset)
		!master_scl_run |=> master_scl_out)
		else $error("scl not idle high");
	c_saturate: cover property (@(posedge mclk) crc_count_r == i2c_timing_pkg::crc_count_max);
	c_slave_start: cover property (@(posedge mclk) slave_start);
	c_override: cover property (@(posedge mclk) repeater_mode && inband_surround_valid);
	c_release: cover property (@(posedge mclk) slave_scl_release);
	c_master_toggle: cover property (@(posedge mclk) $fell(master_scl_out));
endmodule // serializer_i2c_timing_datapath_regs
